// *** brs_ebr_ctl.sv ***
// Fabric-side reset sequencer for an embedded block RAM.
// Assumes the memory end samples enables and strobes on its clock pulses.
//
// Notes on behaviour
// - Enables low one cycle around async reset.
// - Memory global reset always acts asynchronously.
// - Enables on: stop clocks one fmax period.
// - Preloaded memory: release global reset before outputs.
// - FIFO mode keeps global reset always connected.
// - FIFO strobes sequenced like clock enables.
// - FIFO full and pointer resets are asynchronous.
// - Sync reset, global off: no sequencing.
`timescale 1ns/10ps
`default_nettype none
module brs_ebr_ctl #(
  parameter int unsigned DW           = brs_pkg::DATA_W_DEF,
  parameter int unsigned AW           = brs_pkg::ADDR_W_DEF,
  parameter int unsigned CLK_DIV      = brs_pkg::CLK_DIV_DEF,
  parameter int unsigned MEM_FMAX_KHZ = brs_pkg::MEM_FMAX_KHZ_DEF
) (
  // Clock and reset
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  // Configuration
  input  wire logic          cfg_fifo_mode,
  input  wire logic          cfg_gsr_enable,
  input  wire logic          cfg_sync_rst_mode,
  input  wire logic          cfg_keep_enables,
  // Reset requests
  input  wire logic          usr_rst_req,
  input  wire logic          usr_rp_rst_req,
  input  wire logic          usr_gsr_req,
  // Data path requests
  input  wire logic          usr_ce,
  input  wire logic          usr_wr_en,
  input  wire logic          usr_wr_strobe,
  input  wire logic          usr_rd_strobe,
  input  wire logic [AW-1:0] usr_addr,
  input  wire logic [DW-1:0] usr_wr_data,
  // Status and read data
  output logic               usr_busy_r,
  output logic               usr_io_release_r,
  output logic               usr_mem_tick_r,
  output logic [DW-1:0]      usr_rd_data_r,
  output logic               usr_empty_r,
  output logic               usr_full_r,
  // Memory side
  brs_mem_if.ctl             m
);

  // ----------------------------------------------------------------
  // Derived timing
  // ----------------------------------------------------------------
  localparam int unsigned FMAX_PERIOD_NS = (1000000 + MEM_FMAX_KHZ - 1) / MEM_FMAX_KHZ;
  localparam int unsigned STEADY_RAW     = (FMAX_PERIOD_NS + brs_pkg::CORE_CLK_NS - 1) / brs_pkg::CORE_CLK_NS;
  localparam int unsigned STEADY_CYC     = (STEADY_RAW < 1) ? 1 : STEADY_RAW;
  localparam logic [brs_pkg::CNT_W-1:0] STEADY_LAST = brs_pkg::CNT_W'(STEADY_CYC - 1);
  localparam logic [brs_pkg::CNT_W-1:0] DIV_LAST    = brs_pkg::CNT_W'(CLK_DIV - 1);
  localparam logic [brs_pkg::CNT_W-1:0] PRE_LAST    = brs_pkg::CNT_W'(brs_pkg::CE_PRE_PULSES - 1);
  localparam logic [brs_pkg::CNT_W-1:0] HOLD_LAST   = brs_pkg::CNT_W'(brs_pkg::RST_HOLD_PULSES - 1);
  localparam logic [brs_pkg::CNT_W-1:0] POST_LAST   = brs_pkg::CNT_W'(brs_pkg::CE_POST_PULSES - 1);

  if (CLK_DIV < 1 || CLK_DIV > 65535) $error("brs_ebr_ctl: CLK_DIV out of range");
  if (MEM_FMAX_KHZ < 1 || STEADY_CYC > 65535) $error("brs_ebr_ctl: MEM_FMAX_KHZ out of range");
  if (DW < 1 || AW < 1 || AW > 12) $error("brs_ebr_ctl: unsupported geometry");

  // ----------------------------------------------------------------
  // Memory clock divider
  // ----------------------------------------------------------------
  logic [brs_pkg::CNT_W-1:0] div_r;
  logic [brs_pkg::CNT_W-1:0] div_nxt;
  logic                      tick;

  assign tick = (div_r == DIV_LAST);

  always_comb begin
    div_nxt = tick ? '0 : div_r + 1'b1;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= '0;
    end else begin
      div_r <= div_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  brs_pkg::brs_state_e       st_r,   st_nxt;
  brs_pkg::brs_kind_e        kind_r, kind_nxt;
  logic [brs_pkg::CNT_W-1:0] cnt_r,  cnt_nxt;
  logic                      stop_r, stop_nxt;
  logic                      pend_full_r, pend_full_nxt;
  logic                      pend_rp_r,   pend_rp_nxt;
  logic                      pend_gsr_r,  pend_gsr_nxt;
  logic                      step;
  logic                      last;
  logic [brs_pkg::CNT_W-1:0] lim;

  // Gated route counts memory clock pulses; the clock-stop route counts core clock cycles up to one fmax period.
  always_comb begin
    case (st_r)
      brs_pkg::ST_QUIESCE: lim = PRE_LAST;
      brs_pkg::ST_ASSERT:  lim = HOLD_LAST;
      default:             lim = POST_LAST;
    endcase
    if (stop_r) begin
      lim = STEADY_LAST;
    end
    step = stop_r ? 1'b1 : m.rd_clk_pulse;
    last = step && (cnt_r == lim);
  end

  always_comb begin
    st_nxt        = st_r;
    kind_nxt      = kind_r;
    stop_nxt      = stop_r;
    cnt_nxt       = step ? cnt_r + 1'b1 : cnt_r;
    // A request arriving while its pending bit is taken is kept.
    pend_full_nxt = pend_full_r | usr_rst_req;
    pend_rp_nxt   = pend_rp_r | (usr_rp_rst_req & cfg_fifo_mode);
    pend_gsr_nxt  = pend_gsr_r | usr_gsr_req;
    case (st_r)
      brs_pkg::ST_WAKE: begin
        if (last) begin
          st_nxt  = brs_pkg::ST_RELEASE;
          cnt_nxt = '0;
        end
      end
      brs_pkg::ST_IDLE: begin
        cnt_nxt = '0;
        if (pend_gsr_r) begin
          kind_nxt   = brs_pkg::KIND_GSR;
          pend_gsr_nxt = usr_gsr_req;
          st_nxt     = brs_pkg::ST_QUIESCE;
          stop_nxt   = cfg_keep_enables;
        end else if (pend_full_r) begin
          kind_nxt      = brs_pkg::KIND_FULL;
          pend_full_nxt = usr_rst_req;
          if (cfg_sync_rst_mode && !cfg_gsr_enable && !cfg_fifo_mode) begin
            st_nxt = brs_pkg::ST_SYNC;
          end else begin
            st_nxt   = brs_pkg::ST_QUIESCE;
            stop_nxt = cfg_keep_enables;
          end
        end else if (pend_rp_r) begin
          kind_nxt    = brs_pkg::KIND_RDPTR;
          pend_rp_nxt = usr_rp_rst_req & cfg_fifo_mode;
          st_nxt      = brs_pkg::ST_QUIESCE;
          stop_nxt    = cfg_keep_enables;
        end
      end
      brs_pkg::ST_QUIESCE: begin
        if (last) begin
          st_nxt  = brs_pkg::ST_ASSERT;
          cnt_nxt = '0;
        end
      end
      brs_pkg::ST_ASSERT: begin
        if (last) begin
          st_nxt  = brs_pkg::ST_RELEASE;
          cnt_nxt = '0;
        end
      end
      brs_pkg::ST_RELEASE: begin
        if (last) begin
          st_nxt   = brs_pkg::ST_IDLE;
          stop_nxt = 1'b0;
          cnt_nxt  = '0;
        end
      end
      brs_pkg::ST_SYNC: begin
        if (m.rd_clk_pulse) begin
          st_nxt = brs_pkg::ST_IDLE;
        end
      end
      default: begin
        st_nxt = brs_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r        <= brs_pkg::ST_WAKE;
      kind_r      <= brs_pkg::KIND_GSR;
      cnt_r       <= '0;
      stop_r      <= 1'b0;
      pend_full_r <= 1'b0;
      pend_rp_r   <= 1'b0;
      pend_gsr_r  <= 1'b0;
    end else begin
      st_r        <= st_nxt;
      kind_r      <= kind_nxt;
      cnt_r       <= cnt_nxt;
      stop_r      <= stop_nxt;
      pend_full_r <= pend_full_nxt;
      pend_rp_r   <= pend_rp_nxt;
      pend_gsr_r  <= pend_gsr_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Registered memory-side and user-side outputs
  // ----------------------------------------------------------------
  logic rst_on;
  logic gate_all;
  logic gate_rd;
  logic io_rel_r;
  logic io_rel_nxt;

  always_comb begin
    rst_on   = (st_nxt == brs_pkg::ST_ASSERT) || (st_nxt == brs_pkg::ST_WAKE);
    // Enables are held low from quiesce to one cycle after release, unless clocks stop.
    gate_all = !stop_nxt && (st_nxt inside {brs_pkg::ST_WAKE, brs_pkg::ST_QUIESCE,
                                            brs_pkg::ST_ASSERT, brs_pkg::ST_RELEASE})
               && (kind_nxt != brs_pkg::KIND_RDPTR);
    // A read-pointer reset is sequenced against the read strobe only.
    gate_rd  = gate_all || (!stop_nxt && kind_nxt == brs_pkg::KIND_RDPTR
               && st_nxt inside {brs_pkg::ST_QUIESCE, brs_pkg::ST_ASSERT, brs_pkg::ST_RELEASE});
    // Outputs open only once the wake-up global reset has been released.
    io_rel_nxt = io_rel_r || (st_r == brs_pkg::ST_RELEASE && kind_r == brs_pkg::KIND_GSR && last);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      m.wr_clk_pulse            <= 1'b0;
      m.rd_clk_pulse            <= 1'b0;
      m.ce                      <= 1'b0;
      m.wr_en                   <= 1'b0;
      m.wr_strobe               <= 1'b0;
      m.fifo_read_strobe        <= 1'b0;
      m.addr                    <= '0;
      m.wr_data                 <= '0;
      m.async_rst               <= 1'b0;
      m.fifo_read_pointer_reset <= 1'b0;
      m.global_set_reset        <= 1'b1;
      m.gsr_enable              <= 1'b0;
      m.sync_rst                <= 1'b0;
      m.fifo_mode               <= 1'b0;
      io_rel_r                  <= 1'b0;
      usr_busy_r                <= 1'b1;
      usr_io_release_r          <= 1'b0;
      usr_mem_tick_r            <= 1'b0;
      usr_rd_data_r             <= '0;
      usr_empty_r               <= 1'b1;
      usr_full_r                <= 1'b0;
    end else begin
      m.wr_clk_pulse            <= tick & ~stop_nxt;
      m.rd_clk_pulse            <= tick & ~stop_nxt;
      m.ce                      <= usr_ce & ~gate_all;
      m.wr_en                   <= usr_wr_en & ~gate_all;
      m.wr_strobe               <= usr_wr_strobe & ~gate_all;
      m.fifo_read_strobe        <= usr_rd_strobe & ~gate_rd;
      m.addr                    <= usr_addr;
      m.wr_data                 <= usr_wr_data;
      m.async_rst               <= rst_on && kind_nxt == brs_pkg::KIND_FULL;
      m.fifo_read_pointer_reset <= rst_on && kind_nxt == brs_pkg::KIND_RDPTR;
      m.global_set_reset        <= rst_on && kind_nxt == brs_pkg::KIND_GSR;
      m.gsr_enable              <= cfg_gsr_enable;
      m.sync_rst                <= (st_nxt == brs_pkg::ST_SYNC);
      m.fifo_mode               <= cfg_fifo_mode;
      io_rel_r                  <= io_rel_nxt;
      usr_busy_r                <= (st_nxt != brs_pkg::ST_IDLE);
      usr_io_release_r          <= io_rel_nxt;
      usr_mem_tick_r            <= tick & ~stop_nxt;
      usr_rd_data_r             <= m.rd_data;
      usr_empty_r               <= m.fifo_empty;
      usr_full_r                <= m.fifo_full;
    end
  end

endmodule
`default_nettype wire

// *** brs_pkg.sv ***
// Shared constants for the block RAM reset sequencer and its memory end.
// Assumes one 20 MHz core clock drives both ends.
package brs_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CORE_CLK_KHZ     = 20000;
  localparam int unsigned CORE_CLK_NS      = 50;
  localparam int unsigned MEM_FMAX_KHZ_DEF = 20000;
  localparam int unsigned CLK_DIV_DEF      = 2;
  localparam int unsigned CE_PRE_PULSES    = 1;
  localparam int unsigned CE_POST_PULSES   = 1;
  localparam int unsigned RST_HOLD_PULSES  = 1;

  // ----------------------------------------------------------------
  // Geometry and counter width
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W_DEF = 8;
  localparam int unsigned ADDR_W_DEF = 4;
  localparam int unsigned CNT_W      = 16;

  // ----------------------------------------------------------------
  // Sequencer states and reset kinds
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_WAKE,
    ST_IDLE,
    ST_QUIESCE,
    ST_ASSERT,
    ST_RELEASE,
    ST_SYNC
  } brs_state_e;

  typedef enum logic [1:0] {
    KIND_FULL,
    KIND_RDPTR,
    KIND_GSR
  } brs_kind_e;

endpackage

// *** brs_mem_if.sv ***
// Carrier between the fabric-side reset sequencer and the block RAM end.
// Assumes both ends run on the same core clock.
`timescale 1ns/10ps
`default_nettype none
interface brs_mem_if #(
  parameter int unsigned DW = brs_pkg::DATA_W_DEF,
  parameter int unsigned AW = brs_pkg::ADDR_W_DEF
);
  logic          wr_clk_pulse;
  logic          rd_clk_pulse;
  logic          ce;
  logic          wr_en;
  logic          wr_strobe;
  logic          fifo_read_strobe;
  logic [AW-1:0] addr;
  logic [DW-1:0] wr_data;
  logic          async_rst;
  logic          fifo_read_pointer_reset;
  logic          global_set_reset;
  logic          gsr_enable;
  logic          sync_rst;
  logic          fifo_mode;
  logic [DW-1:0] rd_data;
  logic          fifo_empty;
  logic          fifo_full;

  modport ctl (
    output wr_clk_pulse, rd_clk_pulse, ce, wr_en, wr_strobe, fifo_read_strobe, addr, wr_data,
    output async_rst, fifo_read_pointer_reset, global_set_reset, gsr_enable, sync_rst, fifo_mode,
    input  rd_data, fifo_empty, fifo_full
  );
  modport mem (
    input  wr_clk_pulse, rd_clk_pulse, ce, wr_en, wr_strobe, fifo_read_strobe, addr, wr_data,
    input  async_rst, fifo_read_pointer_reset, global_set_reset, gsr_enable, sync_rst, fifo_mode,
    output rd_data, fifo_empty, fifo_full
  );
endinterface
`default_nettype wire

// *** brs_ebr_mem.sv ***
// Embedded block RAM end: RAM or FIFO storage with asynchronous resets.
// Assumes the sequencer end keeps the enable timing around every reset.
`timescale 1ns/10ps
`default_nettype none
module brs_ebr_mem #(
  parameter int unsigned DW = brs_pkg::DATA_W_DEF,
  parameter int unsigned AW = brs_pkg::ADDR_W_DEF
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Memory ports
  brs_mem_if.mem    m
);

  if (DW < 1 || AW < 1 || AW > 12) $error("brs_ebr_mem: unsupported geometry");

  // ----------------------------------------------------------------
  // Asynchronous reset terms
  // ----------------------------------------------------------------
  logic gsr_eff;
  logic arst_n;
  logic rp_arst_n;

  // In FIFO mode the global reset cannot be disconnected.
  assign gsr_eff   = m.global_set_reset & (m.gsr_enable | m.fifo_mode);
  // Global, full and read-pointer resets act without any clock edge.
  assign arst_n    = rst_n & ~gsr_eff & ~m.async_rst;
  assign rp_arst_n = arst_n & ~(m.fifo_mode & m.fifo_read_pointer_reset);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [DW-1:0] mem_q [2**AW];
  logic [AW:0]   wr_ptr_r;
  logic [AW:0]   wr_ptr_nxt;
  logic [AW:0]   rd_ptr_r;
  logic [AW:0]   rd_ptr_nxt;
  logic [DW-1:0] rd_data_r;
  logic [DW-1:0] rd_data_nxt;
  logic          empty;
  logic          full;
  logic          wr_go;
  logic          rd_go;
  logic [AW-1:0] wr_idx;
  logic [AW-1:0] rd_idx;

  assign empty = (wr_ptr_r == rd_ptr_r);
  assign full  = (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]) && (wr_ptr_r[AW] != rd_ptr_r[AW]);

  // In FIFO mode the strobes take the place of the clock enable.
  always_comb begin
    wr_go       = m.wr_clk_pulse & (m.fifo_mode ? (m.wr_strobe & ~full) : (m.ce & m.wr_en));
    rd_go       = m.rd_clk_pulse & (m.fifo_mode ? (m.fifo_read_strobe & ~empty) : m.ce);
    wr_idx      = m.fifo_mode ? wr_ptr_r[AW-1:0] : m.addr;
    rd_idx      = m.fifo_mode ? rd_ptr_r[AW-1:0] : m.addr;
    wr_ptr_nxt  = wr_ptr_r;
    rd_ptr_nxt  = rd_ptr_r;
    rd_data_nxt = rd_data_r;
    if (wr_go && m.fifo_mode) begin
      wr_ptr_nxt = wr_ptr_r + 1'b1;
    end
    if (rd_go) begin
      rd_data_nxt = mem_q[rd_idx];
      if (m.fifo_mode) begin
        rd_ptr_nxt = rd_ptr_r + 1'b1;
      end
    end
    // The synchronous reset acts on a read clock edge even with the enable low, so no request is lost.
    if (m.rd_clk_pulse && m.sync_rst && !m.fifo_mode) begin
      rd_data_nxt = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (wr_go) begin
      mem_q[wr_idx] <= m.wr_data;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_r <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge rp_arst_n) begin
    if (!rp_arst_n) begin
      rd_ptr_r  <= '0;
      rd_data_r <= '0;
    end else begin
      rd_ptr_r  <= rd_ptr_nxt;
      rd_data_r <= rd_data_nxt;
    end
  end

  assign m.rd_data    = rd_data_r;
  assign m.fifo_empty = empty;
  assign m.fifo_full  = full;

endmodule
`default_nettype wire

// *** brs_ebr_asserts.sv ***
// Concurrent checks on the carrier between the sequencer and the block RAM end.
// Assumes one core clock and the asynchronous active-low reset of both ends.
`timescale 1ns/10ps
`default_nettype none
module brs_ebr_asserts #(
  parameter int unsigned DW = brs_pkg::DATA_W_DEF
) (
  // Clock and reset
  input wire logic          core_clk,
  input wire logic          rst_n,
  // Memory clocks and enables
  input wire logic          wr_clk_pulse,
  input wire logic          rd_clk_pulse,
  input wire logic          ce,
  input wire logic          wr_en,
  input wire logic          wr_strobe,
  input wire logic          fifo_read_strobe,
  // Resets and configuration
  input wire logic          async_rst,
  input wire logic          fifo_read_pointer_reset,
  input wire logic          global_set_reset,
  input wire logic          gsr_enable,
  input wire logic          sync_rst,
  input wire logic          fifo_mode,
  // Memory outputs
  input wire logic [DW-1:0] rd_data,
  input wire logic          fifo_empty,
  input wire logic          fifo_full
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // A memory clock edge that would act on the array.
  logic live_pulse;
  assign live_pulse = (wr_clk_pulse | rd_clk_pulse) & (ce | wr_en | wr_strobe | fifo_read_strobe);

  property p_rst_gate_ram;
    (async_rst || global_set_reset) && (wr_clk_pulse || rd_clk_pulse) |-> !ce && !wr_en;
  endproperty
  a_rst_gate_ram: assert property (p_rst_gate_ram) else $error("enable active at clock edge during reset");

  property p_rst_gate_fifo;
    (async_rst || global_set_reset) && (wr_clk_pulse || rd_clk_pulse) |-> !wr_strobe && !fifo_read_strobe;
  endproperty
  a_rst_gate_fifo: assert property (p_rst_gate_fifo) else $error("strobe active at clock edge during reset");

  property p_rst_rise_quiet;
    $rose(async_rst) |-> !$past(live_pulse, 1);
  endproperty
  a_rst_rise_quiet: assert property (p_rst_rise_quiet) else $error("reset raised right after a live clock edge");

  // Only the gated route ends its reset phase on a memory clock pulse; the clock-stop route may resume at once.
  property p_rst_fall_quiet;
    $fell(async_rst) && $past(rd_clk_pulse, 1) |-> !live_pulse ##1 !live_pulse;
  endproperty
  a_rst_fall_quiet: assert property (p_rst_fall_quiet) else $error("live clock edge right after reset release");

  property p_gsr_clear;
    global_set_reset && (gsr_enable || fifo_mode) |=> rd_data == '0 && fifo_empty;
  endproperty
  a_gsr_clear: assert property (p_gsr_clear) else $error("global reset did not clear memory at once");

  property p_full_clear;
    async_rst |=> rd_data == '0 && !fifo_full;
  endproperty
  a_full_clear: assert property (p_full_clear) else $error("full reset did not clear memory at once");

  property p_rp_gate;
    fifo_read_pointer_reset && rd_clk_pulse |-> !fifo_read_strobe;
  endproperty
  a_rp_gate: assert property (p_rp_gate) else $error("read strobe active during pointer reset");

  property p_sync_clear;
    sync_rst && rd_clk_pulse && !fifo_mode |=> rd_data == '0 && !async_rst;
  endproperty
  a_sync_clear: assert property (p_sync_clear) else $error("synchronous reset did not clear read data");

  c_full_seq: cover property ($fell(async_rst));
  c_gsr_seq: cover property ($fell(global_set_reset));
  c_rp_seq: cover property ($fell(fifo_read_pointer_reset));
  c_sync_seq: cover property ($fell(sync_rst));
endmodule
`default_nettype wire

// *** brs_ebr_ctl_tb.sv ***
// Self-checking bench: sequencer and memory ends joined by the carrier.
// Assumes the package defaults for widths and a clock divider of 2.
`timescale 1ns/10ps
`default_nettype none
module brs_ebr_ctl_tb;
  localparam int unsigned DW    = brs_pkg::DATA_W_DEF;
  localparam int unsigned AW    = brs_pkg::ADDR_W_DEF;
  localparam int          DEPTH = 1 << AW;

  // ----------------------------------------------------------------
  // Stimulus, outputs and model state
  // ----------------------------------------------------------------
  logic          core_clk          = 1'b0;
  logic          rst_n             = 1'b0;
  logic          cfg_fifo_mode     = 1'b0;
  logic          cfg_gsr_enable    = 1'b1;
  logic          cfg_sync_rst_mode = 1'b0;
  logic          cfg_keep_enables  = 1'b0;
  logic          usr_rst_req       = 1'b0;
  logic          usr_rp_rst_req    = 1'b0;
  logic          usr_gsr_req       = 1'b0;
  logic          usr_ce            = 1'b0;
  logic          usr_wr_en         = 1'b0;
  logic          usr_wr_strobe     = 1'b0;
  logic          usr_rd_strobe     = 1'b0;
  logic [AW-1:0] usr_addr          = '0;
  logic [DW-1:0] usr_wr_data       = '0;
  logic          usr_busy_r;
  logic          usr_io_release_r;
  logic [DW-1:0] usr_rd_data_r;
  logic          usr_empty_r;
  logic          usr_full_r;
  logic [DW-1:0] ram_m [DEPTH];
  logic [DW-1:0] fifo_m [DEPTH];
  int            wp;
  int            rp;
  int            error_cnt;
  int            cmp_count;
  logic          saw;
  logic [AW-1:0] a;

  brs_mem_if #(.DW(DW), .AW(AW)) bus ();

  brs_ebr_ctl #(.DW(DW), .AW(AW), .CLK_DIV(2)) brs_ebr_ctl_i (
    .core_clk(core_clk), .rst_n(rst_n), .cfg_fifo_mode(cfg_fifo_mode), .cfg_gsr_enable(cfg_gsr_enable),
    .cfg_sync_rst_mode(cfg_sync_rst_mode), .cfg_keep_enables(cfg_keep_enables), .usr_rst_req(usr_rst_req),
    .usr_rp_rst_req(usr_rp_rst_req), .usr_gsr_req(usr_gsr_req), .usr_ce(usr_ce), .usr_wr_en(usr_wr_en),
    .usr_wr_strobe(usr_wr_strobe), .usr_rd_strobe(usr_rd_strobe), .usr_addr(usr_addr),
    .usr_wr_data(usr_wr_data), .usr_busy_r(usr_busy_r), .usr_io_release_r(usr_io_release_r),
    .usr_mem_tick_r(), .usr_rd_data_r(usr_rd_data_r), .usr_empty_r(usr_empty_r), .usr_full_r(usr_full_r),
    .m(bus.ctl));

  brs_ebr_mem #(.DW(DW), .AW(AW)) brs_ebr_mem_i (.core_clk(core_clk), .rst_n(rst_n), .m(bus.mem));

  brs_ebr_asserts #(.DW(DW)) brs_ebr_asserts_i (
    .core_clk(core_clk), .rst_n(rst_n), .wr_clk_pulse(bus.wr_clk_pulse), .rd_clk_pulse(bus.rd_clk_pulse),
    .ce(bus.ce), .wr_en(bus.wr_en), .wr_strobe(bus.wr_strobe), .fifo_read_strobe(bus.fifo_read_strobe),
    .async_rst(bus.async_rst), .fifo_read_pointer_reset(bus.fifo_read_pointer_reset),
    .global_set_reset(bus.global_set_reset), .gsr_enable(bus.gsr_enable), .sync_rst(bus.sync_rst),
    .fifo_mode(bus.fifo_mode), .rd_data(bus.rd_data), .fifo_empty(bus.fifo_empty), .fifo_full(bus.fifo_full));

  always #25 core_clk = ~core_clk;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic chk_bit(input string nm, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      $display("mismatch %s expected %b seen %b", nm, exp, got);
      error_cnt++;
    end
  endtask

  task automatic chk_data(input string nm, input logic [DW-1:0] exp, input logic [DW-1:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", nm, exp, got);
      error_cnt++;
    end
  endtask

  // Waits for the sequence to end and notes whether the full reset line rose.
  task automatic wait_idle(output logic seen);
    seen = 1'b0;
    for (int i = 0; i < 200 && (i < 2 || usr_busy_r !== 1'b0); i++) begin
      if (bus.async_rst === 1'b1) seen = 1'b1;
      step(1);
    end
    chk_bit("busy", 1'b0, usr_busy_r);
  endtask

  task automatic request(input int kind);
    usr_rst_req = (kind == 0);
    usr_rp_rst_req = (kind == 1);
    usr_gsr_req = (kind == 2);
    step(1);
    {usr_rst_req, usr_rp_rst_req, usr_gsr_req} = 3'b000;
    step(2);
  endtask

  // Leaves the enable up so that a later reset meets a live read.
  task automatic ram_access(input logic wr, input logic [AW-1:0] ad, input logic [DW-1:0] d);
    usr_ce = 1'b1;
    usr_wr_en = wr;
    usr_addr = ad;
    usr_wr_data = d;
    step(6);
    if (wr) ram_m[ad] = d;
    else chk_data("ram_rd_data", ram_m[ad], usr_rd_data_r);
  endtask

  // Two strobe cycles hold exactly one memory clock edge.
  task automatic fifo_op(input logic wr, input logic [DW-1:0] d);
    usr_wr_strobe = wr;
    usr_rd_strobe = !wr;
    usr_wr_data = d;
    step(2);
    {usr_wr_strobe, usr_rd_strobe} = 2'b00;
    step(3);
    if (wr && wp - rp < DEPTH) begin
      fifo_m[wp % DEPTH] = d;
      wp++;
    end
    if (!wr && wp != rp) begin
      chk_data("fifo_rd_data", fifo_m[rp % DEPTH], usr_rd_data_r);
      rp++;
    end
    chk_bit("fifo_full", wp - rp == DEPTH, usr_full_r);
    chk_bit("fifo_empty", wp == rp, usr_empty_r);
  endtask

  task automatic results;
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    #1000000;
    error_cnt++;
    results();
  end

  initial begin
    void'($urandom(89));
    repeat (6) @(posedge core_clk);
    #1 rst_n = 1'b1;
    chk_bit("io_release", 1'b0, usr_io_release_r);
    wait_idle(saw);
    chk_bit("io_release", 1'b1, usr_io_release_r);
    for (int i = 0; i < DEPTH; i++) ram_access(1'b1, AW'(i), DW'($urandom));
    for (int i = 0; i < DEPTH; i++) ram_access(1'b0, AW'(i), '0);
    // Full and global resets on both routes, each against a live read.
    for (int k = 0; k < 4; k++) begin
      cfg_keep_enables = k[0];
      a = AW'($urandom);
      ram_access(1'b0, a, '0);
      request(k[1] ? 2 : 0);
      chk_bit("busy", 1'b1, usr_busy_r);
      wait_idle(saw);
      chk_bit("full_reset_line", !k[1], saw);
      ram_access(1'b0, a, '0);
    end
    cfg_keep_enables = 1'b0;
    cfg_gsr_enable = 1'b0;
    cfg_sync_rst_mode = 1'b1;
    request(0);
    wait_idle(saw);
    chk_bit("full_reset_line", 1'b0, saw);
    ram_access(1'b0, a, '0);
    cfg_sync_rst_mode = 1'b0;
    usr_ce = 1'b0;
    cfg_fifo_mode = 1'b1;
    wp = 0;
    rp = 0;
    request(0);
    wait_idle(saw);
    for (int i = 0; i < 3; i++) fifo_op(1'b1, DW'($urandom));
    request(2);
    wait_idle(saw);
    wp = 0;
    rp = 0;
    chk_bit("fifo_empty", 1'b1, usr_empty_r);
    for (int i = 0; i <= DEPTH; i++) fifo_op(1'b1, DW'($urandom));
    for (int i = 0; i <= DEPTH; i++) fifo_op(1'b0, '0);
    fifo_op(1'b1, DW'($urandom));
    request(0);
    wait_idle(saw);
    wp = 0;
    rp = 0;
    chk_bit("fifo_empty", 1'b1, usr_empty_r);
    for (int i = 0; i < 3; i++) fifo_op(1'b1, DW'($urandom));
    for (int i = 0; i < 2; i++) fifo_op(1'b0, '0);
    request(1);
    wait_idle(saw);
    rp = 0;
    chk_bit("fifo_empty", 1'b0, usr_empty_r);
    for (int i = 0; i < 4; i++) fifo_op(1'b0, '0);
    results();
  end
endmodule
`default_nettype wire
